// [core/adc_ctrl_pkg.sv]
// Shared constants and types for the successive-approximation converter
// Operation
// - Eight-bit approximation clocked at oscillator over twelve
// - Step sequence matches seventy microseconds at 8MHz
// - Start write begins conversion, clears done flag
// - Completion sets done flag, result valid
// - One conversion per start, never automatic
// - Start during conversion abandons it, restarts
// - Start bit is write-only, reads zero
// - Done flag with enable raises vector-4 request
// - Control bit 7 enables interrupt
// - Control bit 6 is read-only done flag
// - Control bit 5 is start bit
// - Control bit 4 powers converter, zero idles
// - Wait state never powers the comparator down
// - Reset aborts, control 40h, interrupt masked
// - Result register at D0h is read-only
// - Code steps are supply span over 256
// - Sync option holds start until core waits
// - End-of-conversion request wakes core from wait
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] RESULT_ADDR = 8'hD0;
    localparam logic [7:0] CTRL_ADDR = 8'hD1;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int IRQ_EN_BIT = 7;
    localparam int DONE_BIT = 6;
    localparam int START_BIT = 5;
    localparam int PWR_BIT = 4;

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    localparam int RES_BITS = 8;
    localparam int OSC_DIV = 12;
    localparam int CONV_TIME_NS = 70000;
    localparam int REF_OSC_KHZ = 8000;
    // Conversion clock ticks in one conversion, rounded down
    localparam int CONV_TICKS =
        (CONV_TIME_NS * REF_OSC_KHZ) / (1000000 * OSC_DIV);
    localparam int BIT_TICKS = 5;
    localparam int IRQ_VECTOR = 4;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_HOLD,
        CONV_SAMPLE,
        CONV_TRIAL
    } conv_state_t;

endpackage

// [core/conv_clk_if.sv]
// Link between the sequencer and the conversion clock divider
interface conv_clk_if;
    logic run;
    logic restart;
    logic tick;

    modport gen (
        input run,
        input restart,
        output tick
    );

    modport user (
        output run,
        output restart,
        input tick
    );
endinterface

// [core/conv_tick_gen.sv]
// Conversion clock divider producing one tick every DIV clocks
module conv_tick_gen #(
    parameter int DIV = adc_ctrl_pkg::OSC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Sequencer side
    conv_clk_if.gen link
);
    import adc_ctrl_pkg::*;

    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] DIV_LAST = W'(DIV - 1);

    if (DIV < 2) begin : g_bad_div
        $error("conv_tick_gen: DIV must be at least 2");
    end

    logic [W-1:0] div_q;
    logic [W-1:0] div_d;
    wire at_end = div_q == DIV_LAST;
    wire hold = !link.run || link.restart;

    // Count phase; restart realigns to a fresh period
    assign div_d = (hold || at_end) ? '0 : div_q + 1'b1;
    assign link.tick = link.run && !link.restart && at_end;

    // Phase register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule

// [core/sar_adc_control.sv]
// Register file and sequencer of the 8-bit SAR converter
module sar_adc_control #(
    parameter int CLK_DIV = adc_ctrl_pkg::OSC_DIV,
    parameter int TOTAL_TICKS = adc_ctrl_pkg::CONV_TICKS,
    parameter int STEP_TICKS = adc_ctrl_pkg::BIT_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog front end
    output logic [adc_ctrl_pkg::RES_BITS-1:0] dac_code,
    output logic sample_en,
    output logic converter_power_enable,
    input wire logic comp_above,
    // Core coordination
    input wire logic sync_start_option,
    input wire logic core_in_wait,
    // Status and interrupt
    output logic conv_busy,
    output logic conv_irq
);
    import adc_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------
    localparam int SAMPLE_TICKS = TOTAL_TICKS - RES_BITS * STEP_TICKS;
    localparam int CNT_W = $clog2(TOTAL_TICKS + 1);
    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_TICKS - 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_TICKS - 1);
    localparam logic [2:0] MSB_IDX = 3'(RES_BITS - 1);
    localparam logic [2:0] LSB_IDX = 3'h0;

    // Refuse timings the sequencer cannot serve
    if (STEP_TICKS < 1 || SAMPLE_TICKS < 1) begin : g_bad_timing
        $error("sar_adc_control: TOTAL_TICKS too short for steps");
    end
    if (RES_BITS != 8) begin : g_bad_width
        $error("sar_adc_control: only 8-bit results are supported");
    end

    // ------------------------------------------------------------
    // Trial code decoding
    // ------------------------------------------------------------
    // Kept bits plus the bit under trial
    function automatic logic [7:0] trial_of(
        input logic [7:0] base,
        input logic [2:0] idx
    );
        trial_of = base | (8'h01 << idx);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    conv_state_t state_q;
    conv_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [7:0] approx_q;
    logic [7:0] approx_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic eai_q;
    logic eai_d;
    logic eoc_q;
    logic eoc_d;
    logic pwr_q;
    logic pwr_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] dac_q;
    logic [7:0] dac_d;
    logic sample_q;
    logic busy_q;
    logic irq_q;
    logic irq_d;

    // ------------------------------------------------------------
    // Conversion clock
    // ------------------------------------------------------------
    conv_clk_if link ();

    conv_tick_gen #(
        .DIV(CLK_DIV)
    ) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .link(link)
    );

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire ctrl_sel = reg_addr == CTRL_ADDR;
    wire result_sel = reg_addr == RESULT_ADDR;
    wire ctrl_wr = reg_wr && ctrl_sel;
    // Start pulse from a one in bit 5
    wire start_wr = ctrl_wr && reg_wdata[START_BIT];

    // Control fields as software writes them
    assign eai_d = ctrl_wr ? reg_wdata[IRQ_EN_BIT] : eai_q;
    assign pwr_d = ctrl_wr ? reg_wdata[PWR_BIT] : pwr_q;

    // Control view; start reads zero, low nibble reads zero
    wire [7:0] ctrl_view = {
        eai_q,
        eoc_q,
        1'b0,
        pwr_q,
        4'h0
    };

    // Read mux; unmapped addresses read zero
    assign rdata_d = !reg_rd ? READ_ZERO :
                     ctrl_sel ? ctrl_view :
                     result_sel ? result_q :
                     READ_ZERO;

    // ------------------------------------------------------------
    // Sequencer decode
    // ------------------------------------------------------------
    wire in_sample = state_q == CONV_SAMPLE;
    wire in_trial = state_q == CONV_TRIAL;
    wire cnt_last = cnt_q == (in_sample ? SAMPLE_LAST : STEP_LAST);
    wire step_end = link.tick && cnt_last;
    wire last_bit = bit_q == LSB_IDX;

    // Code under trial and the decision at step end
    wire [7:0] trial_code = trial_of(approx_q, bit_q);
    wire [7:0] decided = comp_above ? trial_code : approx_q;

    // Last decision of a powered conversion completes it
    wire conv_done = in_trial && step_end && last_bit && pwr_d;

    // Divider runs only while sampling or trialling
    assign link.run = in_sample || in_trial;
    assign link.restart = start_wr;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // Start and power take priority over stepping
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        approx_d = approx_q;
        if (!pwr_d) begin
            state_d = CONV_IDLE;
        end else if (start_wr) begin
            // Fresh conversion, abandoning any running one
            cnt_d = '0;
            bit_d = MSB_IDX;
            approx_d = '0;
            if (sync_start_option) begin
                state_d = CONV_HOLD;
            end else begin
                state_d = CONV_SAMPLE;
            end
        end else begin
            case (state_q)
                CONV_IDLE: begin
                    state_d = CONV_IDLE;
                end
                CONV_HOLD: begin
                    // Wait for the core to enter its wait state
                    if (core_in_wait) begin
                        state_d = CONV_SAMPLE;
                    end
                end
                CONV_SAMPLE: begin
                    if (link.tick) begin
                        if (cnt_last) begin
                            cnt_d = '0;
                            state_d = CONV_TRIAL;
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                CONV_TRIAL: begin
                    if (link.tick) begin
                        if (cnt_last) begin
                            cnt_d = '0;
                            approx_d = decided;
                            if (last_bit) begin
                                state_d = CONV_IDLE;
                            end else begin
                                bit_d = bit_q - 1'b1;
                            end
                        end else begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = CONV_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flag, result and outputs
    // ------------------------------------------------------------
    // A start in the completing cycle masks the tick, so start wins over completion
    assign eoc_d = conv_done ? 1'b1 :
                   start_wr ? 1'b0 :
                   eoc_q;

    // Result loads only with the flag
    assign result_d = conv_done ? decided : result_q;

    // Level request; also serves as wake from wait
    assign irq_d = eoc_d && eai_d;

    // Code presented to the comparator during trials
    assign dac_d = (state_d == CONV_TRIAL) ?
                   trial_of(approx_d, bit_d) : 8'h00;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset aborts conversion and returns the sequencer to idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= CONV_IDLE;
            cnt_q <= '0;
            bit_q <= MSB_IDX;
            approx_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            approx_q <= approx_d;
        end
    end

    // Control fields and result
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            eai_q <= CTRL_RESET[IRQ_EN_BIT];
            eoc_q <= CTRL_RESET[DONE_BIT];
            pwr_q <= CTRL_RESET[PWR_BIT];
            result_q <= RESULT_RESET;
        end else begin
            eai_q <= eai_d;
            eoc_q <= eoc_d;
            pwr_q <= pwr_d;
            result_q <= result_d;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= READ_ZERO;
            dac_q <= 8'h00;
            sample_q <= 1'b0;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            dac_q <= dac_d;
            sample_q <= state_d == CONV_SAMPLE;
            busy_q <= state_d != CONV_IDLE;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign dac_code = dac_q;
    assign sample_en = sample_q;
    assign converter_power_enable = pwr_q;
    assign conv_busy = busy_q;
    assign conv_irq = irq_q;

endmodule

// [dv/adc_ctrl_props.sv]
// Port-level checks of the converter control block
module adc_ctrl_props #(
    parameter int CLK_DIV = adc_ctrl_pkg::OSC_DIV,
    parameter int TOTAL_TICKS = adc_ctrl_pkg::CONV_TICKS,
    parameter int STEP_TICKS = adc_ctrl_pkg::BIT_TICKS
) (
    // Clock, reset and register port
    input logic clk,
    input logic reset_n,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Converter side and status
    input logic [adc_ctrl_pkg::RES_BITS-1:0] dac_code,
    input logic sample_en,
    input logic converter_power_enable,
    input logic comp_above,
    input logic sync_start_option,
    input logic core_in_wait,
    input logic conv_busy,
    input logic conv_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctrl_pkg::*;
    localparam int CONV_CLKS = TOTAL_TICKS * CLK_DIV;
    logic ctl_wr, start_go, ok_q, ok_d;
    logic [15:0] cnt_q, cnt_d;

    // Plain start decode and untouched-run tracking
    assign ctl_wr = reg_wr && reg_addr == CTRL_ADDR;
    assign start_go = ctl_wr && reg_wdata[START_BIT]
        && reg_wdata[PWR_BIT] && !sync_start_option;
    assign cnt_d = start_go ? 16'h0000 : cnt_q + 16'h0001;
    assign ok_d = start_go || ok_q && !ctl_wr;
    // Cycles since the last plain start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            ok_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ok_q <= ok_d;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    read_idle_a:
        assert property (!$past(reg_rd) |-> reg_rdata == READ_ZERO)
        else $error("read data not zero outside a read");
    start_reads_zero_a:
        assert property ($past(reg_rd && reg_addr == CTRL_ADDR)
            |-> reg_rdata[START_BIT] == 1'b0 && reg_rdata[3:0] == 4'h0)
        else $error("write-only or unused control bits read as one");
    power_follows_a:
        assert property (ctl_wr |=> converter_power_enable
            == $past(reg_wdata[PWR_BIT]))
        else $error("power enable does not follow control write");
    start_runs_a:
        assert property (start_go |=> conv_busy && sample_en)
        else $error("start write did not begin sampling");
    conv_length_a:
        assert property ($fell(conv_busy) && ok_q |-> cnt_q == CONV_CLKS)
        else $error("conversion length wrong");
    irq_masked_a:
        assert property (ctl_wr && !reg_wdata[IRQ_EN_BIT]
            |=> !conv_irq)
        else $error("interrupt request not masked");
    busy_cause_a:
        assert property ($rose(conv_busy)
            |-> $past(ctl_wr && reg_wdata[START_BIT]))
        else $error("conversion began without a start write");
    sync_hold_a:
        assert property ($rose(conv_busy) && sync_start_option
            && !core_in_wait |-> !sample_en)
        else $error("synchronised start did not wait");
endmodule

bind sar_adc_control adc_ctrl_props #(
    .CLK_DIV(CLK_DIV),
    .TOTAL_TICKS(TOTAL_TICKS),
    .STEP_TICKS(STEP_TICKS)
) props_i (.*);

// [dv/analog_src.sv]
// Behavioural input source and comparator on one analog pin
module analog_src (
    // Clock
    input logic clk,
    // Converter side
    input logic [adc_ctrl_pkg::RES_BITS-1:0] dac_code,
    input logic converter_power_enable,
    output logic comp_above,
    // Input level set by the bench
    input logic [7:0] vin
);
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctrl_pkg::*;
    logic noise_q = 1'b0;
    // Unpowered comparator output wanders every cycle
    always @(posedge clk) noise_q <= ~noise_q;
    // Single selected pin, code steps of span over 256
    assign comp_above = converter_power_enable ? vin >= dac_code
        : noise_q;
endmodule

// [dv/tb.sv]
// Self-checking bench for the converter control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_ctrl_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sync_start_option = 1'b0;
    logic core_in_wait = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] vin = 8'h00;
    logic [7:0] reg_rdata, dac_code, d;
    logic sample_en, converter_power_enable, comp_above, conv_busy;
    logic conv_irq;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'h80, 8'h7F};

    // Clock, design with short counts, input source
    always #20 clk = ~clk;
    sar_adc_control #(.CLK_DIV(2), .TOTAL_TICKS(9), .STEP_TICKS(1))
        sar_adc_control_i (.*);
    analog_src analog_src_i (.*);

    // Compare, register access and bounded wait
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic idle;
        int i;
        for (i = 0; i < 100; i++) begin
            @(negedge clk);
            if (conv_busy === 1'b0) break;
        end
        if (i == 100) begin
            num_errors++;
            $display("ERROR %0t: conversion hung", $time);
            final_report;
        end
    endtask
    task automatic final_report;
        $display("Mismatches %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Test sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(CTRL_ADDR);
        chk(d, 8'h40);
        wr(8'h3C, 8'hFF);
        wr(RESULT_ADDR, 8'hFF);
        rd(8'h3C);
        chk(d, 8'h00);
        rd(RESULT_ADDR);
        chk(d, 8'h00);
        wr(CTRL_ADDR, 8'h1F);
        rd(CTRL_ADDR);
        chk(d, 8'h50);
        // Boundary codes with the interrupt enabled
        foreach (codes[k]) begin
            @(posedge clk) vin <= codes[k];
            wr(CTRL_ADDR, 8'hB0);
            idle;
            rd(RESULT_ADDR);
            chk(d, codes[k]);
            rd(CTRL_ADDR);
            chk(d, 8'hD0);
            chk({7'h00, conv_irq}, 8'h01);
        end
        // Start clears the flag, reads zero, no second run
        wr(CTRL_ADDR, 8'hB0);
        rd(CTRL_ADDR);
        chk(d, 8'h90);
        chk({7'h00, conv_irq}, 8'h00);
        idle;
        repeat (40) @(posedge clk);
        chk({7'h00, conv_busy}, 8'h00);
        // Mask and unmask with the flag pending
        wr(CTRL_ADDR, 8'h10);
        repeat (2) @(posedge clk);
        chk({7'h00, conv_irq}, 8'h00);
        rd(CTRL_ADDR);
        chk(d, 8'h50);
        wr(CTRL_ADDR, 8'h90);
        repeat (2) @(posedge clk);
        chk({7'h00, conv_irq}, 8'h01);
        // Restart mid-run; old result held meanwhile
        @(posedge clk) vin <= 8'h3C;
        wr(CTRL_ADDR, 8'h30);
        rd(RESULT_ADDR);
        chk(d, 8'h7F);
        // Input moves once the upper bits are decided
        repeat (4) @(posedge clk);
        @(posedge clk) vin <= 8'h5A;
        wr(CTRL_ADDR, 8'h30);
        idle;
        rd(RESULT_ADDR);
        chk(d, 8'h5A);
        chk({7'h00, conv_irq}, 8'h00);
        // Power removed mid-run aborts without a flag
        wr(CTRL_ADDR, 8'h30);
        repeat (4) @(posedge clk);
        wr(CTRL_ADDR, 8'h00);
        repeat (20) @(negedge clk);
        chk({7'h00, conv_busy}, 8'h00);
        rd(CTRL_ADDR);
        chk(d, 8'h00);
        // Synchronised start waits for the core
        wr(CTRL_ADDR, 8'h10);
        @(posedge clk) sync_start_option <= 1'b1;
        vin <= 8'hC3;
        wr(CTRL_ADDR, 8'h30);
        repeat (10) @(posedge clk);
        chk({6'h00, conv_busy, sample_en}, 8'h02);
        @(posedge clk) core_in_wait <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(dac_code, 8'h80);
        idle;
        rd(RESULT_ADDR);
        chk(d, 8'hC3);
        sync_start_option <= 1'b0;
        // Reset in mid-run
        wr(CTRL_ADDR, 8'hB0);
        repeat (5) @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk({7'h00, conv_busy}, 8'h00);
        rd(CTRL_ADDR);
        chk(d, 8'h40);
        final_report;
    end
endmodule
